// ===== common/mode_sync_if.sv
// Carrier for the synchronised switch and operator levels.
// Assumes one clock domain; driven by the input synchroniser only.
`timescale 1ns/100ps
interface mode_sync_if #(
    parameter int MODES = 8
);
    logic [MODES-1:0] modes;
    logic             activate;
    logic             errorReset;
    logic             acknowledge;
    logic             lockRelease;

    modport src (output modes, activate, errorReset, acknowledge, lockRelease);
    modport dst (input  modes, activate, errorReset, acknowledge, lockRelease);
endinterface : mode_sync_if

// ===== common/safe_mode_pkg.sv
// Constants, codes and register map of the safe mode selector.
// Assumes a single 50 MHz clock and a plain strobe register port.
package safe_mode_pkg;

    // ****************************************************************
    // Sizes and timing
    // ****************************************************************
    localparam int          MODE_COUNT       = 8;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    localparam int          CODE_W           = 16;
    localparam int          EVENT_W          = 4;
    localparam int          CLK_FREQ_HZ      = 50_000_000;
    localparam int          WATCH_TIME_MS    = 100;
    localparam int          WATCH_CYCLES_DEF = WATCH_TIME_MS * (CLK_FREQ_HZ / 1000);

    // ****************************************************************
    // Diagnostic codes
    // ****************************************************************
    localparam logic [15:0] CODE_IDLE        = 16'h0000;
    localparam logic [15:0] CODE_AWAIT       = 16'h8005;
    localparam logic [15:0] CODE_UNLATCHED   = 16'h8000;
    localparam logic [15:0] CODE_LATCHED     = 16'h8004;
    localparam logic [15:0] CODE_SHORT       = 16'hc001;
    localparam logic [15:0] CODE_OPEN        = 16'hc002;
    localparam logic [15:0] CODE_RST_SHORT   = 16'hc003;
    localparam logic [15:0] CODE_RST_OPEN    = 16'hc004;

    // ****************************************************************
    // Register map (byte addresses) and fields
    // ****************************************************************
    localparam logic [7:0]  OFS_STATUS       = 8'h00;
    localparam logic [7:0]  OFS_MASK         = 8'h04;
    localparam logic [7:0]  OFS_CONFIG       = 8'h08;
    localparam logic [7:0]  OFS_WATCH        = 8'h0c;
    localparam logic [7:0]  OFS_CODE         = 8'h10;
    localparam int          EV_SHORT         = 0;
    localparam int          EV_OPEN          = 1;
    localparam int          EV_RST_FAULT     = 2;
    localparam int          EV_CONFIRM       = 3;
    localparam int          CFG_AUTO_ACK     = 0;
    localparam logic [3:0]  MASK_RESET       = 4'h0;
    localparam logic        AUTO_ACK_RESET   = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_AWAIT,
        ST_UNLATCHED,
        ST_LATCHED,
        ST_ERR_SHORT,
        ST_ERR_OPEN,
        ST_ERR_RST_SHORT,
        ST_ERR_RST_OPEN
    } sel_state_t;

endpackage : safe_mode_pkg

// ===== test/mode_switch_model.sv
// Model of the multi-position selector switch.
// Assumes the bench sets the position just after a rising edge.
`timescale 1ns/100ps
module mode_switch_model #(
    parameter int MODES = 8
) (
    // Commands
    input  wire logic [3:0]       position,
    input  wire logic             shorted,
    // Switch contacts
    output logic      [MODES-1:0] contacts
);
    // A position beyond the last mode models a broken cable: no contact closes.
    always_comb begin
        if (shorted) begin
            contacts = MODES'(8'h81);
        end else if (position < MODES) begin
            contacts = MODES'(8'h01) << position;
        end else begin
            contacts = '0;
        end
    end
endmodule : mode_switch_model

// ===== test/safe_mode_selector_sva.sv
// Concurrent checks on the safe mode selector outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module safe_mode_selector_sva
    import safe_mode_pkg::*;
#(
    parameter int MODES = 8
) (
    // Clock and reset
    input wire logic             core_clk,
    input wire logic             rst_n,
    // Switch and enable pins
    input wire logic [MODES-1:0] mode_input_n,
    input wire logic             activate,
    // Results
    input wire logic [MODES-1:0] mode_confirmed_out_n,
    input wire logic             any_mode_confirmed,
    input wire logic             ready,
    input wire logic             error,
    input wire logic [15:0]      diagnostic_code
);
    // ****************************************************************
    // Output relations
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_error_outs_safe: assert property (error |-> ready && !any_mode_confirmed
        && !(|mode_confirmed_out_n)) else $error("error state shows a selection");
    chk_error_code: assert property (error == (diagnostic_code[15:12] == 4'hc))
        else $error("error flag and code disagree");
    chk_idle_quiet: assert property (diagnostic_code == CODE_IDLE |-> !ready && !error
        && !any_mode_confirmed && !(|mode_confirmed_out_n)) else $error("idle not quiet");
    chk_await_outs: assert property (diagnostic_code == CODE_AWAIT |-> ready && !error
        && !any_mode_confirmed && !(|mode_confirmed_out_n)) else $error("await outputs");
    chk_unlatched_one: assert property (diagnostic_code == CODE_UNLATCHED |-> ready
        && any_mode_confirmed && !error && $onehot(mode_confirmed_out_n))
        else $error("unlatched outputs");
    chk_latched_one: assert property (diagnostic_code == CODE_LATCHED |-> ready
        && any_mode_confirmed && !error && $onehot(mode_confirmed_out_n))
        else $error("latched outputs");
    chk_error_exit: assert property ($fell(error) && ready |-> diagnostic_code == CODE_AWAIT)
        else $error("error left to wrong state");
    // The input filter delays a pin by four edges and the output register by one more, so eight samples leave margin.
    chk_idle_wins: assert property (!activate [*8] |-> diagnostic_code == CODE_IDLE)
        else $error("inactive but not idle");
    chk_short_fast: assert property ((activate && $countones(mode_input_n) > 1) [*8]
        |-> error) else $error("short not flagged");
endmodule : safe_mode_selector_sva

bind safe_mode_selector safe_mode_selector_sva #(.MODES(MODES)) safe_mode_selector_sva_i (
    .core_clk(core_clk), .rst_n(rst_n), .mode_input_n(mode_input_n), .activate(activate),
    .mode_confirmed_out_n(mode_confirmed_out_n), .any_mode_confirmed(any_mode_confirmed),
    .ready(ready), .error(error), .diagnostic_code(diagnostic_code)
);

// ===== test/safe_mode_selector_tb.sv
// Self-checking bench for the safe mode selector.
// Assumes the watch limit starts at 20 cycles, is set to 30 by software, and pins settle.
`timescale 1ns/100ps
module safe_mode_selector_tb;
    import safe_mode_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, activate = 1'b0, errorReset = 1'b0;
    logic        ackIn = 1'b0, lockRelease = 1'b1, shorted = 1'b0, regWrite = 1'b0;
    logic        regRead = 1'b0, anyMode, ready, error, irq;
    logic [3:0]  position = 4'h8;
    logic [7:0]  modes, outs, regAddr = 8'h00;
    logic [15:0] code;
    logic [31:0] regWriteData = 32'h0, regReadData;
    int          n_fail = 0, cmp_count = 0;

    mode_switch_model mode_switch_model_i (.position(position), .shorted(shorted),
        .contacts(modes));
    safe_mode_selector #(.WATCH_CYCLES(20)) safe_mode_selector_i (.core_clk(core_clk),
        .rst_n(rst_n), .mode_input_n(modes), .activate(activate), .errorReset(errorReset),
        .acknowledge_input(ackIn), .lockRelease(lockRelease), .mode_confirmed_out_n(outs),
        .any_mode_confirmed(anyMode), .ready(ready), .error(error), .diagnostic_code(code),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData), .irq(irq));

    initial forever #10 core_clk = ~core_clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chk(what, exp, regReadData);
    endtask : rdchk
    // Waits for the pin filter, checks, and returns just after an edge.
    task automatic settle(input int n, input logic [15:0] c, input logic [7:0] o);
        repeat (n) @(posedge core_clk);
        #1 chk("code", {16'h0, c}, {16'h0, code});
        chk("outs", {24'h0, o}, {24'h0, outs});
        chk("flags", {29'h0, (c != CODE_IDLE), (c[15:12] == 4'hc),
            (c == CODE_UNLATCHED || c == CODE_LATCHED)}, {29'h0, ready, error, anyMode});
        @(posedge core_clk);
    endtask : settle
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        #100000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(8, CODE_IDLE, 8'h00);
        rdchk("watch", OFS_WATCH, 32'h14);
        wr(OFS_WATCH, 32'h1e);
        rdchk("watch", OFS_WATCH, 32'h1e);
        rdchk("unmapped", 8'h20, 32'h0);
        wr(OFS_MASK, 32'hf);
        activate <= 1'b1;
        settle(8, CODE_AWAIT, 8'h00);
        position <= 4'h3;
        ackIn <= 1'b1;
        settle(8, CODE_UNLATCHED, 8'h08);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("status", OFS_STATUS, 32'h8);
        wr(OFS_MASK, 32'h0);
        rdchk("mask", OFS_MASK, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFS_STATUS, 32'h8);
        wr(OFS_MASK, 32'hf);
        rdchk("status", OFS_STATUS, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        lockRelease <= 1'b0;
        settle(8, CODE_LATCHED, 8'h08);
        lockRelease <= 1'b1;
        settle(8, CODE_UNLATCHED, 8'h08);
        ackIn <= 1'b0;
        position <= 4'h8;
        settle(8, CODE_AWAIT, 8'h00);
        settle(40, CODE_OPEN, 8'h00);
        rdchk("status", OFS_STATUS, 32'h2);
        errorReset <= 1'b1;
        settle(8, CODE_AWAIT, 8'h00);
        shorted <= 1'b1;
        settle(8, CODE_RST_SHORT, 8'h00);
        rdchk("status", OFS_STATUS, 32'h6);
        shorted <= 1'b0;
        errorReset <= 1'b0;
        settle(8, CODE_RST_SHORT, 8'h00);
        errorReset <= 1'b1;
        settle(8, CODE_AWAIT, 8'h00);
        errorReset <= 1'b0;
        shorted <= 1'b1;
        settle(8, CODE_SHORT, 8'h00);
        errorReset <= 1'b1;
        shorted <= 1'b0;
        settle(8, CODE_AWAIT, 8'h00);
        settle(40, CODE_RST_OPEN, 8'h00);
        errorReset <= 1'b0;
        settle(8, CODE_RST_OPEN, 8'h00);
        wr(OFS_CONFIG, 32'h1);
        rdchk("config", OFS_CONFIG, 32'h1);
        errorReset <= 1'b1;
        position <= 4'h5;
        settle(8, CODE_UNLATCHED, 8'h20);
        position <= 4'h8;
        lockRelease <= 1'b0;
        settle(8, CODE_AWAIT, 8'h00);
        rdchk("code reg", OFS_CODE, 32'h0001_8005);
        activate <= 1'b0;
        settle(8, CODE_IDLE, 8'h00);
        // A reset in mid-run must bring every register back to its reset value.
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rdchk("watch reset", OFS_WATCH, 32'h14);
        rdchk("mask reset", OFS_MASK, 32'h0);
        rdchk("config reset", OFS_CONFIG, 32'h0);
        rdchk("status reset", OFS_STATUS, 32'h0);
        settle(8, CODE_IDLE, 8'h00);
        summarize();
    end
endmodule : safe_mode_selector_tb

// ===== verilog/mode_input_sync.sv
// Three-stage synchroniser with agreement filter for all pin inputs.
// Assumes pins are asynchronous to core_clk; outputs change one clock after agreement.
`timescale 1ns/100ps
module mode_input_sync
    import safe_mode_pkg::*;
#(
    parameter int MODES = safe_mode_pkg::MODE_COUNT
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Raw pins
    input  wire logic [MODES-1:0] modePins,
    input  wire logic             activatePin,
    input  wire logic             errorResetPin,
    input  wire logic             acknowledgePin,
    input  wire logic             lockReleasePin,
    // Filtered levels
    mode_sync_if.src              levels
);
    localparam int W = MODES + 4;

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] held;
    logic [W-1:0] next_held;

    // ****************************************************************
    // Filter
    // ****************************************************************
    // Each bit moves only where the second and third stages agree, so
    // a glitch caught in a single stage never reaches the state machine.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_held[i] = (stage2[i] == stage3[i]) ? stage3[i] : held[i];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            held   <= '0;
        end else begin
            stage1 <= {lockReleasePin, acknowledgePin, errorResetPin, activatePin, modePins};
            stage2 <= stage1;
            stage3 <= stage2;
            held   <= next_held;
        end
    end

    assign levels.modes       = held[MODES-1:0];
    assign levels.activate    = held[MODES];
    assign levels.errorReset  = held[MODES+1];
    assign levels.acknowledge = held[MODES+2];
    assign levels.lockRelease = held[MODES+3];

endmodule : mode_input_sync

// ===== verilog/safe_mode_selector.sv
// Safe mode selector: confirms one of up to eight switch positions and
// latches short- and open-circuit faults with a diagnostic code.
// Assumes switch and operator inputs are asynchronous pins and that
// software uses a single-cycle strobe register port on core_clk.
`timescale 1ns/100ps
module safe_mode_selector
    import safe_mode_pkg::*;
#(
    parameter int unsigned WATCH_CYCLES = safe_mode_pkg::WATCH_CYCLES_DEF,
    parameter int          MODES        = safe_mode_pkg::MODE_COUNT
) (
    // Clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                rst_n,
    // Switch and operator pins
    input  wire logic [MODES-1:0]                    mode_input_n,
    input  wire logic                                activate,
    input  wire logic                                errorReset,
    input  wire logic                                acknowledge_input,
    input  wire logic                                lockRelease,
    // Selection results
    output logic      [MODES-1:0]                    mode_confirmed_out_n,
    output logic                                     any_mode_confirmed,
    output logic                                     ready,
    output logic                                     error,
    output logic      [safe_mode_pkg::CODE_W-1:0]    diagnostic_code,
    // Register port
    input  wire logic [safe_mode_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic [safe_mode_pkg::DATA_W-1:0]    regWriteData,
    input  wire logic                                regWrite,
    input  wire logic                                regRead,
    output logic      [safe_mode_pkg::DATA_W-1:0]    regReadData,
    // Interrupt
    output logic                                     irq
);
    import safe_mode_pkg::*;

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    mode_sync_if #(.MODES(MODES)) lv ();

    mode_input_sync #(.MODES(MODES)) u_sync (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .modePins       (mode_input_n),
        .activatePin    (activate),
        .errorResetPin  (errorReset),
        .acknowledgePin (acknowledge_input),
        .lockReleasePin (lockRelease),
        .levels         (lv.src)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    sel_state_t              state;
    sel_state_t              next_state;
    logic [MODES-1:0]        chosen;
    logic [MODES-1:0]        next_chosen;
    logic [MODES-1:0]        prevModes;
    logic                    prevReset;
    logic                    prevAck;
    logic [31:0]             watchCount;
    logic [31:0]             next_watchCount;
    logic [MODES-1:0]        next_confirmed;
    logic                    next_any;
    logic                    next_ready;
    logic                    next_error;
    logic [CODE_W-1:0]       next_code;
    logic [EVENT_W-1:0]      eventPulse;

    // Registers
    logic [EVENT_W-1:0]      status;
    logic [EVENT_W-1:0]      next_status;
    logic [EVENT_W-1:0]      mask;
    logic [EVENT_W-1:0]      next_mask;
    logic                    autoAck;
    logic                    next_autoAck;
    logic [31:0]             watchLimit;
    logic [31:0]             next_watchLimit;
    logic [DATA_W-1:0]       next_readData;

    // ****************************************************************
    // Decoded input conditions
    // ****************************************************************
    logic [3:0]              activeCount;
    logic                    manyActive;
    logic                    oneActive;
    logic                    noneActive;
    logic                    anyFell;
    logic                    resetRise;
    logic                    ackRise;
    logic                    watchExpired;
    logic                    inError;

    always_comb begin
        activeCount = 4'h0;
        for (int i = 0; i < MODES; i++) begin
            activeCount = activeCount + {3'h0, lv.modes[i]};
        end
    end

    assign manyActive   = (activeCount > 4'h1);
    assign oneActive    = (activeCount == 4'h1);
    assign noneActive   = (activeCount == 4'h0);
    assign anyFell      = |(prevModes & ~lv.modes);
    assign resetRise    = lv.errorReset & ~prevReset;
    assign ackRise      = lv.acknowledge & ~prevAck;
    assign watchExpired = noneActive && (watchCount >= watchLimit);
    assign inError      = (state == ST_ERR_SHORT) || (state == ST_ERR_OPEN) ||
                          (state == ST_ERR_RST_SHORT) || (state == ST_ERR_RST_OPEN);

    // ****************************************************************
    // Transition logic
    // ****************************************************************
    always_comb begin
        next_state  = state;
        next_chosen = chosen;
        if (!lv.activate) begin
            next_state = ST_IDLE;
        end else if (inError) begin
            if (resetRise) begin
                next_state = ST_AWAIT;
            end
        end else if (state == ST_IDLE) begin
            next_state = ST_AWAIT;
        end else if (manyActive) begin
            next_state = lv.errorReset ? ST_ERR_RST_SHORT : ST_ERR_SHORT;
        end else if (watchExpired) begin
            next_state = lv.errorReset ? ST_ERR_RST_OPEN : ST_ERR_OPEN;
        end else begin
            case (state)
                ST_AWAIT: begin
                    if (oneActive && (autoAck || ackRise)) begin
                        next_state  = ST_UNLATCHED;
                        next_chosen = lv.modes;
                    end
                end
                ST_UNLATCHED: begin
                    // A changed switch outranks the lock release falling with it.
                    if (lv.modes != chosen) begin
                        next_state = ST_AWAIT;
                    end else if (!lv.lockRelease) begin
                        next_state = ST_LATCHED;
                    end
                end
                ST_LATCHED: begin
                    if (lv.lockRelease) begin
                        next_state = ST_UNLATCHED;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
        if (next_state == ST_IDLE || next_state == ST_AWAIT) begin
            next_chosen = '0;
        end
    end

    // The watch timer only runs while the selector is active, out of fault and sees no contact closed.
    always_comb begin
        if (!lv.activate || inError || state == ST_IDLE || anyFell || !noneActive) begin
            next_watchCount = 32'h0;
        end else if (watchCount != 32'hffffffff) begin
            next_watchCount = watchCount + 32'h1;
        end else begin
            next_watchCount = watchCount;
        end
    end

    // ****************************************************************
    // Output decode from the next state
    // ****************************************************************
    // Outputs are decoded from next_state so the code and the flags move
    // in the very cycle the state register changes.
    always_comb begin
        next_confirmed = '0;
        next_any       = 1'b0;
        next_ready     = 1'b1;
        next_error     = 1'b0;
        case (next_state)
            ST_IDLE: begin
                next_ready = 1'b0;
                next_code  = CODE_IDLE;
            end
            ST_AWAIT: begin
                next_code  = CODE_AWAIT;
            end
            ST_UNLATCHED: begin
                next_confirmed = next_chosen;
                next_any       = 1'b1;
                next_code      = CODE_UNLATCHED;
            end
            ST_LATCHED: begin
                next_confirmed = next_chosen;
                next_any       = 1'b1;
                next_code      = CODE_LATCHED;
            end
            ST_ERR_SHORT: begin
                next_error = 1'b1;
                next_code  = CODE_SHORT;
            end
            ST_ERR_OPEN: begin
                next_error = 1'b1;
                next_code  = CODE_OPEN;
            end
            ST_ERR_RST_SHORT: begin
                next_error = 1'b1;
                next_code  = CODE_RST_SHORT;
            end
            ST_ERR_RST_OPEN: begin
                next_error = 1'b1;
                next_code  = CODE_RST_OPEN;
            end
            default: begin
                next_ready = 1'b0;
                next_code  = CODE_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state                <= ST_IDLE;
            chosen               <= '0;
            prevModes            <= '0;
            prevReset            <= 1'b0;
            prevAck              <= 1'b0;
            watchCount           <= 32'h0;
            mode_confirmed_out_n <= '0;
            any_mode_confirmed   <= 1'b0;
            ready                <= 1'b0;
            error                <= 1'b0;
            diagnostic_code      <= CODE_IDLE;
        end else begin
            state                <= next_state;
            chosen               <= next_chosen;
            prevModes            <= lv.modes;
            prevReset            <= lv.errorReset;
            prevAck              <= lv.acknowledge;
            watchCount           <= next_watchCount;
            mode_confirmed_out_n <= next_confirmed;
            any_mode_confirmed   <= next_any;
            ready                <= next_ready;
            error                <= next_error;
            diagnostic_code      <= next_code;
        end
    end

    // ****************************************************************
    // Events and interrupt
    // ****************************************************************
    always_comb begin
        eventPulse               = '0;
        eventPulse[EV_SHORT]     = (next_state == ST_ERR_SHORT) && (state != ST_ERR_SHORT);
        eventPulse[EV_OPEN]      = (next_state == ST_ERR_OPEN) && (state != ST_ERR_OPEN);
        eventPulse[EV_RST_FAULT] = ((next_state == ST_ERR_RST_SHORT) ||
                                    (next_state == ST_ERR_RST_OPEN)) && !inError;
        eventPulse[EV_CONFIRM]   = (next_state == ST_UNLATCHED) && (state == ST_AWAIT);
    end

    assign irq = |(status & mask);

    // ****************************************************************
    // Register port
    // ****************************************************************
    // A write of one clears a status bit, but an event in the same cycle
    // sets it again, so no fault can slip past software.
    always_comb begin
        next_status     = status;
        next_mask       = mask;
        next_autoAck    = autoAck;
        next_watchLimit = watchLimit;
        next_readData   = '0;
        if (regWrite) begin
            case (regAddr)
                OFS_STATUS: next_status  = status & ~regWriteData[EVENT_W-1:0];
                OFS_MASK:   next_mask    = regWriteData[EVENT_W-1:0];
                OFS_CONFIG: next_autoAck = regWriteData[CFG_AUTO_ACK];
                OFS_WATCH:  next_watchLimit = regWriteData;
                default:    next_status  = status;
            endcase
        end
        next_status = next_status | eventPulse;
        if (regRead) begin
            case (regAddr)
                OFS_STATUS: next_readData = {{(DATA_W-EVENT_W){1'b0}}, status};
                OFS_MASK:   next_readData = {{(DATA_W-EVENT_W){1'b0}}, mask};
                OFS_CONFIG: next_readData = {{(DATA_W-1){1'b0}}, autoAck};
                OFS_WATCH:  next_readData = watchLimit;
                OFS_CODE:   next_readData = {{(DATA_W-CODE_W-3){1'b0}}, state, diagnostic_code};
                default:    next_readData = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status      <= '0;
            mask        <= MASK_RESET;
            autoAck     <= AUTO_ACK_RESET;
            watchLimit  <= WATCH_CYCLES;
            regReadData <= '0;
        end else begin
            status      <= next_status;
            mask        <= next_mask;
            autoAck     <= next_autoAck;
            watchLimit  <= next_watchLimit;
            regReadData <= next_readData;
        end
    end

endmodule : safe_mode_selector
